// file: rtl/irq_cpu_if_sysreg_control.sv
`timescale 1ns/100ps

module irq_cpu_if_sysreg_control #(
	parameter bit       REALM_EXT        = 1'b0, // realm security extension present
	parameter bit       EL2_PRESENT      = 1'b1, // exception level 2 implemented
	parameter bit       IRQ_BYPASS_SUPP  = 1'b1, // irq bypass supported
	parameter bit       FIQ_BYPASS_SUPP  = 1'b1, // fiq bypass supported
	parameter bit       SYSREG_FIXED_ONE = 1'b0, // sysreg enable read-as-one
	parameter bit       TRAP_EN_FIXED    = 1'b0, // trap-enable read-as-one too
	parameter bit       TRAP_EN_RST      = 1'b0, // value for the unknown reset
	parameter bit       HALT_UNDEF_FIRST = 1'b0, // halted undef beats level-2 trap
	parameter int       VIRT_PRI_BITS    = 5,    // virtual priority bits
	parameter int       VIRT_PRE_BITS    = 5,    // virtual preemption bits
	parameter bit       VIRT_ID_24       = 1'b0, // 24-bit virtual identifiers
	parameter bit       SEI_SUPP         = 1'b0, // virtual system error support
	parameter bit       TOP_AFF_SUPP     = 1'b0, // nonzero top affinity support
	parameter bit       DEACT_TRAP_SUPP  = 1'b0, // separate deactivate trap
	parameter bit       DI_MASK_SUPP     = 1'b0, // direct injection masking
	parameter int       LIST_REGS        = 4     // number of list registers
) (
	input  wire logic        i_clk,                 // processor clock
	input  wire logic        i_srst,                // warm reset
	input  wire logic        i_acc_valid,           // access request
	input  wire logic        i_acc_write,           // 1 write, 0 read
	input  wire logic [1:0]  i_op0,                 // encoding op0
	input  wire logic [2:0]  i_op1,                 // encoding op1
	input  wire logic [3:0]  i_crn,                 // encoding crn
	input  wire logic [3:0]  i_crm,                 // encoding crm
	input  wire logic [2:0]  i_op2,                 // encoding op2
	input  wire logic [1:0]  i_el,                  // current exception level
	input  wire logic [63:0] i_wdata,               // write data
	input  wire logic        i_el2_enabled,         // level 2 enabled
	input  wire logic        i_hyp_nested,          // nested virt trap to level 2
	input  wire logic        i_halted,              // core halted in debug
	input  wire logic        i_secure_debug_disable,// secure debug disabled
	input  wire logic        i_hyp_trap_en,         // level-2 trap-enable bit
	input  wire logic        i_hyp_sysreg_on,       // level-2 sysreg enable bit
	output logic             o_acc_done,            // access answered
	output logic             o_acc_undef,           // access is undefined
	output logic             o_trap_el2,            // trap taken to level 2
	output logic             o_trap_el3,            // trap taken to level 3
	output logic [5:0]       o_syndrome,            // trap class
	output logic             o_forward,             // handled by other logic
	output logic [63:0]      o_rdata,               // read data
	output logic             o_sysreg_on,           // sysreg interface at level 3
	output logic             o_lower_trap_en,       // effective trap-enable
	output logic             o_irq_bypass_disable,  // irq bypass off
	output logic             o_fiq_bypass_disable   // fiq bypass off
);

	// ***********************************************************
	// elaboration checks
	// ***********************************************************
	if (VIRT_PRI_BITS < irq_sysreg_pkg::MIN_VIRT_PRI || VIRT_PRI_BITS > 8)
		$error("virtual priority bits out of range");
	if (VIRT_PRE_BITS < irq_sysreg_pkg::MIN_VIRT_PRI
		|| VIRT_PRE_BITS > VIRT_PRI_BITS
		|| VIRT_PRE_BITS > irq_sysreg_pkg::MAX_VIRT_PRE)
		$error("virtual preemption bits out of range");
	if (LIST_REGS < 1 || LIST_REGS > 16)
		$error("list register count out of range");
	if (TRAP_EN_FIXED && !(SYSREG_FIXED_ONE || REALM_EXT))
		$error("fixed trap-enable needs a fixed sysreg enable");
	if (REALM_EXT && !DI_MASK_SUPP)
		$error("realm extension requires masking support");

	// ***********************************************************
	// constant fields of the register
	// ***********************************************************
	localparam bit SYSREG_ONE  = REALM_EXT || SYSREG_FIXED_ONE;
	localparam bit DI_MASK_VAL = REALM_EXT || DI_MASK_SUPP;
	localparam logic [2:0] PRI_CODE  = 3'(VIRT_PRI_BITS - 1);
	localparam logic [2:0] PRE_CODE  = 3'(VIRT_PRE_BITS - 1);
	localparam logic [4:0] LIST_CODE = 5'(LIST_REGS - 1);
	localparam logic [2:0] ID_CODE   = VIRT_ID_24 ? irq_sysreg_pkg::ID_24_BITS
		: irq_sysreg_pkg::ID_16_BITS;

	logic [63:0] vtr_value;

	// type report; without level 2 only the no-direct-injection bit is set
	always_comb
	begin
		vtr_value = 64'h0;
		vtr_value[irq_sysreg_pkg::VTR_NO_DI_BIT] = 1'b1;
		if (EL2_PRESENT)
		begin
			vtr_value[irq_sysreg_pkg::VTR_PRI_LSB +: 3] = PRI_CODE;
			vtr_value[irq_sysreg_pkg::VTR_PRE_LSB +: 3] = PRE_CODE;
			vtr_value[irq_sysreg_pkg::VTR_ID_LSB +: 3]  = ID_CODE;
			vtr_value[irq_sysreg_pkg::VTR_SYS_ERR_BIT] = SEI_SUPP;
			vtr_value[irq_sysreg_pkg::VTR_TOP_AFF_BIT] = TOP_AFF_SUPP;
			vtr_value[irq_sysreg_pkg::VTR_DEACT_BIT]   = DEACT_TRAP_SUPP;
			vtr_value[irq_sysreg_pkg::VTR_DI_MASK_BIT] = DI_MASK_VAL;
			vtr_value[irq_sysreg_pkg::VTR_LIST_LSB +: 5] = LIST_CODE;
		end
	end

	// ***********************************************************
	// stored fields of the top enable register
	// ***********************************************************
	logic sysreg_on_q;
	logic trap_en_q;
	logic irq_byp_q;
	logic fiq_byp_q;
	logic sysreg_on_eff;
	logic trap_en_rd;
	logic trap_en_eff;
	logic top_wr;

	// read views: fixed bits show one, stored bits show themselves
	assign sysreg_on_eff = SYSREG_ONE ? 1'b1 : sysreg_on_q;
	assign trap_en_rd    = TRAP_EN_FIXED ? 1'b1 : trap_en_q;
	// a zero sysreg enable makes the trap-enable behave as one
	assign trap_en_eff   = sysreg_on_eff ? trap_en_rd : 1'b1;

	// ***********************************************************
	// access decode
	// ***********************************************************
	irq_sysreg_pkg::target_t target;

	sysreg_target_decode u_decode (
		.i_op0    (i_op0),
		.i_op1    (i_op1),
		.i_crn    (i_crn),
		.i_crm    (i_crm),
		.i_op2    (i_op2),
		.o_target (target)
	);

	logic halt_secure;

	// halted with secure debug disabled turns level-3 traps from levels 1 and 2 into undef
	assign halt_secure = i_halted && i_secure_debug_disable;

	irq_sysreg_pkg::outcome_t outcome;
	logic                     fwd;
	logic [63:0]              rd_val;

	// trap and undefined priority, one target at a time
	always_comb
	begin
		outcome = irq_sysreg_pkg::out_ok;
		fwd     = 1'b0;
		rd_val  = 64'h0;
		unique case (target)
			irq_sysreg_pkg::tgt_top:
			begin
				if (i_el != irq_sysreg_pkg::EL3)
					outcome = irq_sysreg_pkg::out_undef;
				else
				begin
					rd_val[irq_sysreg_pkg::TOP_EN_BIT]  = trap_en_rd;
					rd_val[irq_sysreg_pkg::TOP_IRQ_BYP_BIT]   = irq_byp_q;
					rd_val[irq_sysreg_pkg::TOP_FIQ_BYP_BIT]   = fiq_byp_q;
					rd_val[irq_sysreg_pkg::TOP_SYSREG_ON_BIT] = sysreg_on_eff;
				end
			end
			irq_sysreg_pkg::tgt_hyp:
			begin
				unique case (i_el)
					irq_sysreg_pkg::EL0:
						outcome = irq_sysreg_pkg::out_undef;
					irq_sysreg_pkg::EL1:
						outcome = (i_el2_enabled && i_hyp_nested)
							? irq_sysreg_pkg::out_trap2 : irq_sysreg_pkg::out_undef;
					irq_sysreg_pkg::EL2:
					begin
						if (!trap_en_eff)
							outcome = halt_secure ? irq_sysreg_pkg::out_undef
								: irq_sysreg_pkg::out_trap3;
						else
							fwd = 1'b1;
					end
					irq_sysreg_pkg::EL3:
					begin
						if (!i_el2_enabled)
							outcome = irq_sysreg_pkg::out_undef;
						else
							fwd = 1'b1;
					end
				endcase
			end
			irq_sysreg_pkg::tgt_kern:
			begin
				unique case (i_el)
					irq_sysreg_pkg::EL0:
						outcome = irq_sysreg_pkg::out_undef;
					irq_sysreg_pkg::EL1:
					begin
						// level-2 trap wins unless the halted undef is ranked first
						if (HALT_UNDEF_FIRST && halt_secure && !trap_en_eff)
							outcome = irq_sysreg_pkg::out_undef;
						else if (i_el2_enabled && !i_hyp_trap_en)
							outcome = irq_sysreg_pkg::out_trap2;
						else if (!trap_en_eff)
							outcome = halt_secure ? irq_sysreg_pkg::out_undef
								: irq_sysreg_pkg::out_trap3;
						else
							fwd = 1'b1;
					end
					irq_sysreg_pkg::EL2:
					begin
						if (!trap_en_eff)
							outcome = halt_secure ? irq_sysreg_pkg::out_undef
								: irq_sysreg_pkg::out_trap3;
						else
							fwd = 1'b1;
					end
					irq_sysreg_pkg::EL3:
						fwd = 1'b1;
				endcase
			end
			irq_sysreg_pkg::tgt_vtr:
			begin
				unique case (i_el)
					irq_sysreg_pkg::EL0:
						outcome = irq_sysreg_pkg::out_undef;
					irq_sysreg_pkg::EL1:
						outcome = (i_el2_enabled && i_hyp_nested)
							? irq_sysreg_pkg::out_trap2 : irq_sysreg_pkg::out_undef;
					irq_sysreg_pkg::EL2:
					begin
						if (!i_hyp_sysreg_on)
							outcome = irq_sysreg_pkg::out_trap2;
						else
							rd_val = vtr_value;
					end
					irq_sysreg_pkg::EL3:
					begin
						if (!sysreg_on_eff)
							outcome = irq_sysreg_pkg::out_trap3;
						else
							rd_val = vtr_value;
					end
				endcase
			end
			irq_sysreg_pkg::tgt_other:
			begin
				// at level 3 the memory-mapped view bars all other registers
				if (i_el == irq_sysreg_pkg::EL3 && !sysreg_on_eff)
					outcome = irq_sysreg_pkg::out_trap3;
				else
					fwd = 1'b1;
			end
			default:
				fwd = 1'b1;
		endcase
	end

	// only a level-3 write through the one encoding may store
	assign top_wr = i_acc_valid && i_acc_write
		&& target == irq_sysreg_pkg::tgt_top
		&& i_el == irq_sysreg_pkg::EL3;

	// ***********************************************************
	// register storage, one process per field
	// ***********************************************************
	// sysreg enable; a 1 to 0 clear is left to software to avoid
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			sysreg_on_q <= irq_sysreg_pkg::SYSREG_ON_RST;
		else if (top_wr && !SYSREG_ONE)
			sysreg_on_q <= i_wdata[irq_sysreg_pkg::TOP_SYSREG_ON_BIT];
	end

	// trap-enable; its reset value is a parameter since it is unknown
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			trap_en_q <= TRAP_EN_RST;
		else if (top_wr && !TRAP_EN_FIXED)
			trap_en_q <= i_wdata[irq_sysreg_pkg::TOP_EN_BIT];
	end

	// irq bypass disable; pinned to one where bypass does not exist
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			irq_byp_q <= IRQ_BYPASS_SUPP ? irq_sysreg_pkg::IRQ_BYP_RST : 1'b1;
		else if (!IRQ_BYPASS_SUPP)
			irq_byp_q <= 1'b1;
		else if (top_wr)
			irq_byp_q <= i_wdata[irq_sysreg_pkg::TOP_IRQ_BYP_BIT];
	end

	// fiq bypass disable; same treatment as the irq bit
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			fiq_byp_q <= FIQ_BYPASS_SUPP ? irq_sysreg_pkg::FIQ_BYP_RST : 1'b1;
		else if (!FIQ_BYPASS_SUPP)
			fiq_byp_q <= 1'b1;
		else if (top_wr)
			fiq_byp_q <= i_wdata[irq_sysreg_pkg::TOP_FIQ_BYP_BIT];
	end

	// ***********************************************************
	// answer to the access, one cycle after the request
	// ***********************************************************
	// the result flags are registered so outputs come from flops
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_acc_done  <= 1'b0;
			o_acc_undef <= 1'b0;
			o_trap_el2  <= 1'b0;
			o_trap_el3  <= 1'b0;
			o_forward   <= 1'b0;
		end
		else
		begin
			o_acc_done  <= i_acc_valid;
			o_acc_undef <= i_acc_valid && outcome == irq_sysreg_pkg::out_undef;
			o_trap_el2  <= i_acc_valid && outcome == irq_sysreg_pkg::out_trap2;
			o_trap_el3  <= i_acc_valid && outcome == irq_sysreg_pkg::out_trap3;
			o_forward   <= i_acc_valid && fwd;
		end
	end

	// syndrome is the system access class on any trap, else zero
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			o_syndrome <= 6'h0;
		else if (i_acc_valid && (outcome == irq_sysreg_pkg::out_trap2
			|| outcome == irq_sysreg_pkg::out_trap3))
			o_syndrome <= irq_sysreg_pkg::EC_SYS_TRAP;
		else
			o_syndrome <= 6'h0;
	end

	// read data only for a successful read; zero hides stale values
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			o_rdata <= 64'h0;
		else if (i_acc_valid && !i_acc_write && outcome == irq_sysreg_pkg::out_ok)
			o_rdata <= rd_val;
		else
			o_rdata <= 64'h0;
	end

	// ***********************************************************
	// control levels for the rest of the interface
	// ***********************************************************
	// registered copies lag the stored fields by one cycle
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_sysreg_on          <= 1'b0;
			o_lower_trap_en      <= 1'b1;
			o_irq_bypass_disable <= !IRQ_BYPASS_SUPP;
			o_fiq_bypass_disable <= !FIQ_BYPASS_SUPP;
		end
		else
		begin
			o_sysreg_on          <= sysreg_on_eff;
			o_lower_trap_en      <= trap_en_eff;
			o_irq_bypass_disable <= irq_byp_q;
			o_fiq_bypass_disable <= fiq_byp_q;
		end
	end

endmodule

// file: shared/irq_sysreg_pkg.sv
package irq_sysreg_pkg;

	// ***********************************************************
	// instruction encoding of the registers in this bank
	// ***********************************************************
	localparam logic [1:0] OP0_SYS     = 2'h3;
	localparam logic [3:0] CRN_IF      = 4'hc;
	localparam logic [2:0] TOP_OP1     = 3'h6;
	localparam logic [3:0] TOP_CRM     = 4'hc;
	localparam logic [2:0] TOP_OP2     = 3'h5;
	localparam logic [2:0] HYP_OP1     = 3'h4;
	localparam logic [3:0] HYP_CRM     = 4'h9;
	localparam logic [2:0] HYP_OP2     = 3'h5;
	localparam logic [2:0] KERN_OP1    = 3'h0;
	localparam logic [3:0] KERN_CRM    = 4'hc;
	localparam logic [2:0] KERN_OP2    = 3'h5;
	localparam logic [2:0] VTR_OP1     = 3'h4;
	localparam logic [3:0] VTR_CRM     = 4'hb;
	localparam logic [2:0] VTR_OP2     = 3'h1;

	// ***********************************************************
	// exception levels and trap syndrome
	// ***********************************************************
	localparam logic [1:0] EL0         = 2'h0;
	localparam logic [1:0] EL1         = 2'h1;
	localparam logic [1:0] EL2         = 2'h2;
	localparam logic [1:0] EL3         = 2'h3;
	localparam logic [5:0] EC_SYS_TRAP = 6'h18;

	// ***********************************************************
	// top_level_sysreg_enable fields and reset values
	// ***********************************************************
	localparam int         TOP_EN_BIT        = 3;
	localparam int         TOP_IRQ_BYP_BIT   = 2;
	localparam int         TOP_FIQ_BYP_BIT   = 1;
	localparam int         TOP_SYSREG_ON_BIT = 0;
	localparam logic       IRQ_BYP_RST       = 1'b0;
	localparam logic       FIQ_BYP_RST       = 1'b0;
	localparam logic       SYSREG_ON_RST     = 1'b0;

	// ***********************************************************
	// virtual_if_type_report fields
	// ***********************************************************
	localparam int         VTR_PRI_LSB  = 29;
	localparam int         VTR_PRE_LSB  = 26;
	localparam int         VTR_ID_LSB   = 23;
	localparam int         VTR_SYS_ERR_BIT = 22;
	localparam int         VTR_TOP_AFF_BIT = 21;
	localparam int         VTR_NO_DI_BIT   = 20;
	localparam int         VTR_DEACT_BIT   = 19;
	localparam int         VTR_DI_MASK_BIT = 18;
	localparam int         VTR_LIST_LSB = 0;
	localparam logic [2:0] ID_16_BITS   = 3'h0;
	localparam logic [2:0] ID_24_BITS   = 3'h1;
	localparam int         MIN_VIRT_PRI = 5;
	localparam int         MAX_VIRT_PRE = 7;

	// ***********************************************************
	// decoded target and access outcome
	// ***********************************************************
	typedef enum logic [2:0] {
		tgt_none  = 3'h0,
		tgt_top   = 3'h1,
		tgt_hyp   = 3'h3,
		tgt_kern  = 3'h2,
		tgt_vtr   = 3'h6,
		tgt_other = 3'h7
	} target_t;

	typedef enum logic [1:0] {
		out_ok    = 2'h0,
		out_undef = 2'h1,
		out_trap2 = 2'h3,
		out_trap3 = 2'h2
	} outcome_t;

endpackage

// file: rtl/sysreg_target_decode.sv
`timescale 1ns/100ps

// ***********************************************************
// maps a system register encoding onto one bank target
// ***********************************************************
module sysreg_target_decode (
	input  wire logic [1:0]              i_op0,    // op0 field
	input  wire logic [2:0]              i_op1,    // op1 field
	input  wire logic [3:0]              i_crn,    // crn field
	input  wire logic [3:0]              i_crm,    // crm field
	input  wire logic [2:0]              i_op2,    // op2 field
	output irq_sysreg_pkg::target_t      o_target  // decoded target
);

	// one register matches when op1, crm and op2 agree
	function automatic logic enc_match(
		input logic [2:0] op1,
		input logic [3:0] crm,
		input logic [2:0] op2,
		input logic [2:0] want_op1,
		input logic [3:0] want_crm,
		input logic [2:0] want_op2
	);
		return (op1 == want_op1) && (crm == want_crm) && (op2 == want_op2);
	endfunction

	logic in_space;

	// only the interface space is ours; everything else is tgt_none
	assign in_space = (i_op0 == irq_sysreg_pkg::OP0_SYS)
		&& (i_crn == irq_sysreg_pkg::CRN_IF);

	// priority order is irrelevant: the encodings are disjoint
	always_comb
	begin
		o_target = irq_sysreg_pkg::tgt_none;
		if (in_space)
		begin
			if (enc_match(i_op1, i_crm, i_op2, irq_sysreg_pkg::TOP_OP1,
				irq_sysreg_pkg::TOP_CRM, irq_sysreg_pkg::TOP_OP2))
				o_target = irq_sysreg_pkg::tgt_top;
			else if (enc_match(i_op1, i_crm, i_op2, irq_sysreg_pkg::HYP_OP1,
				irq_sysreg_pkg::HYP_CRM, irq_sysreg_pkg::HYP_OP2))
				o_target = irq_sysreg_pkg::tgt_hyp;
			else if (enc_match(i_op1, i_crm, i_op2, irq_sysreg_pkg::KERN_OP1,
				irq_sysreg_pkg::KERN_CRM, irq_sysreg_pkg::KERN_OP2))
				o_target = irq_sysreg_pkg::tgt_kern;
			else if (enc_match(i_op1, i_crm, i_op2, irq_sysreg_pkg::VTR_OP1,
				irq_sysreg_pkg::VTR_CRM, irq_sysreg_pkg::VTR_OP2))
				o_target = irq_sysreg_pkg::tgt_vtr;
			else
				o_target = irq_sysreg_pkg::tgt_other;
		end
	end

endmodule

// file: verification/irq_cpu_if_sysreg_control_properties.sv
`timescale 1ns/100ps

// ***********************************************************
// port-level properties of the sysreg control bank
// ***********************************************************
module irq_cpu_if_sysreg_control_properties (
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic        i_acc_valid,
	input  wire logic        i_acc_write,
	input  wire logic [1:0]  i_op0,
	input  wire logic [2:0]  i_op1,
	input  wire logic [3:0]  i_crn,
	input  wire logic [3:0]  i_crm,
	input  wire logic [2:0]  i_op2,
	input  wire logic [1:0]  i_el,
	input  wire logic        i_halted,
	input  wire logic        o_acc_done,
	input  wire logic        o_acc_undef,
	input  wire logic        o_trap_el2,
	input  wire logic        o_trap_el3,
	input  wire logic [5:0]  o_syndrome,
	input  wire logic        o_forward,
	input  wire logic [63:0] o_rdata,
	input  wire logic        o_sysreg_on,
	input  wire logic        o_lower_trap_en,
	input  wire logic        o_irq_bypass_disable,
	input  wire logic        o_fiq_bypass_disable
);
	// report of the default build only: 5/5 bits, 16-bit ids, 4 list regs
	localparam logic [63:0] VTR_DEF = 64'h0000_0000_9010_0003;
	logic                   sys_space;
	logic                   top_enc;
	logic                   hyp_enc;

	// encodings decoded here so each property reads plainly
	assign sys_space = i_op0 == 2'h3 && i_crn == 4'hc;
	assign top_enc   = sys_space && {i_op1, i_crm, i_op2} == {3'h6, 4'hc, 3'h5};
	assign hyp_enc   = sys_space && {i_op1, i_crm, i_op2} == {3'h4, 4'h9, 3'h5};

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);

	chk_done_next: assert property (i_acc_valid |=> o_acc_done)
		else $error("access not answered one cycle later");
	chk_top_low_undef: assert property (i_acc_valid && top_enc && i_el != 2'h3 |=> o_acc_undef)
		else $error("top enable access below level 3 not undefined");
	chk_trap_syndrome: assert property ((o_trap_el2 || o_trap_el3) |-> o_acc_done && o_syndrome == 6'h18)
		else $error("trap without its syndrome");
	chk_lower_trap_on: assert property (!o_sysreg_on |-> o_lower_trap_en)
		else $error("trap-enable not acting as one");
	chk_report_value: assert property (i_acc_valid && !i_acc_write && sys_space && i_el == 2'h3
		&& {i_op1, i_crm, i_op2} == {3'h4, 4'hb, 3'h1} |=> o_trap_el3 || o_rdata == VTR_DEF)
		else $error("type report read wrong");
	chk_reset_state: assert property ($past(i_srst) |-> !o_sysreg_on && !o_irq_bypass_disable
		&& !o_fiq_bypass_disable)
		else $error("control outputs not at reset values");
	chk_hyp_write_trap: assert property (i_acc_valid && i_acc_write && hyp_enc && i_el == 2'h2
		&& !i_halted && !o_lower_trap_en && !$past(i_acc_valid) |=> o_trap_el3)
		else $error("level-2 enable write did not trap");
	chk_outside_fwd: assert property (i_acc_valid && i_op0 != 2'h3 |=> o_forward && !o_acc_undef)
		else $error("foreign encoding not forwarded");
	chk_rdata_quiet: assert property (!o_acc_done |-> o_rdata == 64'h0 && o_syndrome == 6'h0)
		else $error("answer data outside done cycle");
endmodule

bind irq_cpu_if_sysreg_control irq_cpu_if_sysreg_control_properties i_props (
	.i_clk, .i_srst, .i_acc_valid, .i_acc_write, .i_op0, .i_op1, .i_crn, .i_crm, .i_op2,
	.i_el, .i_halted, .o_acc_done, .o_acc_undef, .o_trap_el2, .o_trap_el3, .o_syndrome,
	.o_forward, .o_rdata, .o_sysreg_on, .o_lower_trap_en, .o_irq_bypass_disable,
	.o_fiq_bypass_disable
);

// file: verification/tb_irq_cpu_if_sysreg_control.sv
`timescale 1ns/100ps

// ***********************************************************
// bench for the sysreg control bank, default build
// ***********************************************************
module tb_irq_cpu_if_sysreg_control;
	// {done, undef, trap2, trap3, forward, syndrome}
	localparam logic [10:0] R_OK = 11'h400, R_UND = 11'h600, R_T2 = 11'h518;
	localparam logic [10:0] R_T3 = 11'h498, R_FWD = 11'h440;
	// {op1, crm, op2}: top, hyp, kernel, report, other, foreign
	localparam logic [9:0]  ENC [6] = '{10'h365, 10'h24d, 10'h065, 10'h259, 10'h364, 10'h365};
	logic        i_clk = 1'b0, i_srst = 1'b1, i_acc_valid = 1'b0, i_acc_write = 1'b0;
	logic [1:0]  i_op0 = 2'h3, i_el = 2'h3;
	logic [2:0]  i_op1 = 3'h0, i_op2 = 3'h0;
	logic [3:0]  i_crn = 4'hc, i_crm = 4'h0;
	logic [63:0] i_wdata = 64'h0, o_rdata, rd;
	logic        i_el2_enabled = 1'b1, i_hyp_nested = 1'b0, i_halted = 1'b0;
	logic        i_secure_debug_disable = 1'b0, i_hyp_trap_en = 1'b1, i_hyp_sysreg_on = 1'b1;
	logic        o_acc_done, o_acc_undef, o_trap_el2, o_trap_el3, o_forward, o_sysreg_on;
	logic        o_lower_trap_en, o_irq_bypass_disable, o_fiq_bypass_disable;
	logic [5:0]  o_syndrome;
	logic [10:0] resp;
	int          err_count = 0, checks = 0, cycles = 0;

	irq_cpu_if_sysreg_control i_irq_cpu_if_sysreg_control (
		.i_clk, .i_srst, .i_acc_valid, .i_acc_write, .i_op0, .i_op1, .i_crn, .i_crm, .i_op2,
		.i_el, .i_wdata, .i_el2_enabled, .i_hyp_nested, .i_halted, .i_secure_debug_disable,
		.i_hyp_trap_en, .i_hyp_sysreg_on, .o_acc_done, .o_acc_undef, .o_trap_el2, .o_trap_el3,
		.o_syndrome, .o_forward, .o_rdata, .o_sysreg_on, .o_lower_trap_en,
		.o_irq_bypass_disable, .o_fiq_bypass_disable
	);

	always #5 i_clk = ~i_clk;

	// a hung access must still reach the verdict
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			err_count++;
			complete_run();
		end
	end

	task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one access, answer sampled after the done edge has landed
	task automatic run(input int t, input logic w, input logic [1:0] el, input logic [63:0] wd,
		input logic [10:0] exp);
		@(posedge i_clk);
		{i_acc_valid, i_acc_write, i_op0, i_op1, i_crm, i_op2, i_el, i_wdata} <=
			{1'b1, w, (t == 5) ? 2'h2 : 2'h3, ENC[t], el, wd};
		@(posedge i_clk);
		i_acc_valid <= 1'b0;
		#1;
		resp = {o_acc_done, o_acc_undef, o_trap_el2, o_trap_el3, o_forward, o_syndrome};
		rd = o_rdata;
		check_val({53'h0, resp}, {53'h0, exp});
	endtask

	task automatic check_levels(input logic [3:0] exp);
		check_val({60'h0, o_sysreg_on, o_lower_trap_en, o_irq_bypass_disable,
			o_fiq_bypass_disable}, {60'h0, exp});
	endtask

	task automatic test_reset();
		check_levels(4'h4);
		run(0, 1'b0, 2'h3, 64'h0, R_OK);
		check_val(rd, 64'h0);
		run(3, 1'b0, 2'h3, 64'h0, R_T3);
		run(4, 1'b0, 2'h3, 64'h0, R_T3);
		run(5, 1'b0, 2'h3, 64'h0, R_FWD);
		run(1, 1'b1, 2'h2, 64'h0, R_FWD);
	endtask

	// lower levels may neither read nor write the top register
	task automatic test_low_el();
		for (int e = 0; e < 3; e++)
		begin
			run(0, 1'b1, e[1:0], 64'hf, R_UND);
			run(0, 1'b0, e[1:0], 64'h0, R_UND);
		end
		run(0, 1'b0, 2'h3, 64'h0, R_OK);
		check_val(rd, 64'h0);
	endtask

	task automatic test_sre_off();
		run(0, 1'b1, 2'h3, 64'h8, R_OK);
		run(0, 1'b0, 2'h3, 64'h0, R_OK);
		check_val(rd, 64'h8);
		check_levels(4'h4);
	endtask

	task automatic test_enable();
		run(0, 1'b1, 2'h3, 64'hffff_ffff_ffff_ffff, R_OK);
		run(0, 1'b0, 2'h3, 64'h0, R_OK);
		check_val(rd, 64'hf);
		check_levels(4'hf);
		run(3, 1'b1, 2'h3, 64'h0, R_OK);
		run(3, 1'b0, 2'h3, 64'h0, R_OK);
		check_val(rd, 64'h9010_0003);
		run(4, 1'b0, 2'h3, 64'h0, R_FWD);
	endtask

	// trap-enable cleared with the interface on: lower levels trap
	task automatic test_trap();
		run(0, 1'b1, 2'h3, 64'h1, R_OK);
		@(posedge i_clk);
		#1;
		check_levels(4'h8);
		run(1, 1'b1, 2'h2, 64'h0, R_T3);
		run(2, 1'b0, 2'h2, 64'h0, R_T3);
		run(2, 1'b1, 2'h1, 64'h0, R_T3);
		@(posedge i_clk);
		i_hyp_trap_en <= 1'b0;
		run(2, 1'b0, 2'h1, 64'h0, R_T2);
		@(posedge i_clk);
		{i_hyp_trap_en, i_halted, i_secure_debug_disable} <= 3'h7;
		run(1, 1'b1, 2'h2, 64'h0, R_UND);
	endtask

	// level-2 side inputs steer the remaining outcomes
	task automatic test_side_inputs();
		@(posedge i_clk);
		{i_hyp_nested, i_hyp_sysreg_on} <= 2'h2;
		run(3, 1'b0, 2'h2, 64'h0, R_T2);
		run(1, 1'b1, 2'h1, 64'h0, R_T2);
		run(2, 1'b0, 2'h0, 64'h0, R_UND);
		@(posedge i_clk);
		i_el2_enabled <= 1'b0;
		run(1, 1'b0, 2'h3, 64'h0, R_UND);
		run(0, 1'b0, 2'h3, 64'h0, R_OK);
		check_val(rd, 64'h1);
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		repeat (12) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		#1;
		test_reset();
		test_low_el();
		test_sre_off();
		test_enable();
		test_trap();
		test_side_inputs();
		complete_run();
	end
endmodule
